// file: bench/serial_link_command_port_bench.sv
// self-checking bench for the serial link command port
module serial_link_command_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] pres = 8'h00;
  logic [7:0] fset = 8'h00;
  logic [7:0] mute = 8'h00;
  logic [7:0] dly = 8'h01;
  logic [7:0] ack, nak, act, stp, xreq, m, m2, ea, ok;
  logic hrdy, hresp, prst, lrst, phy;
  logic rd_dp = 1'b0;
  logic [31:0] hrdata, rd_v, v, m_e;
  logic [31:0] exp_q[$];
  string nm_q[$];
  string m_n;
  int err_total, comparisons, seed, lnk_cnt;
  logic [7:0] ptab [8] = '{8'h12, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00,
                           8'h5a, 8'h08};

  always #25 clk = ~clk;

  slcp_command_port u_dut (
    .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HREADYOUT(hrdy),
    .O_HRDATA(hrdata), .O_HRESP(hresp), .I_CHAN_PRESENT(pres),
    .I_XFER_DONE(ack), .I_XFER_FAIL(nak), .O_CHAN_ACTIVE(act),
    .O_CHAN_SETUP(stp), .O_XFER_REQ(xreq), .O_PROC_RESET(prst),
    .O_LINK_RESET(lrst), .O_PHY_CLK(phy)
  );

  slcp_chan_model u_chan (
    .i_clk(clk), .i_resetn(rst_n), .i_req(xreq), .i_fail_set(fset),
    .i_mute(mute), .i_dly(dly), .o_done(ack), .o_fail(nak)
  );

  // ********
  // checking and bus tasks
  // ********
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hready is sampled at each edge; nothing moves until it is high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
  endtask

  // an empty name marks a poll whose value is not compared
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd_v = hrdata;
  endtask

  // polls until the command register reads zero; a poll limit that
  // runs out is counted as a mismatch
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(slcp_pkg::OFF_CMD, 32'h0, "");
      n++;
    end while (rd_v !== 32'h0 && n < 3000);
    check("cmd done", rd_v, 32'h0);
  endtask

  task automatic cmd(input logic [31:0] w);
    wr(slcp_pkg::OFF_CMD, w);
    idle();
  endtask

  always @(posedge clk) begin
    if (rd_dp && hrdy === 1'b1) begin
      rd_dp = 1'b0;
      m_e = exp_q.pop_front();
      m_n = nm_q.pop_front();
      if (m_n != "") check(m_n, hrdata, m_e);
    end
    if (hsel && htrans[1] && hrdy === 1'b1 && !hwrite) rd_dp = 1'b1;
    if (lrst === 1'b1) lnk_cnt++;
  end

  initial begin
    #(30000 * 50);
    err_total++;
    end_sim();
  end

  // ********
  // tests
  // ********
  initial begin
    seed = 26886;
    pres = $random(seed) | 1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(slcp_pkg::OFF_CMD, 32'h0, "cmd reset");
    rd(slcp_pkg::OFF_DATA, 32'h0, "data reset");
    rd(slcp_pkg::OFF_CHAN, 32'h0, "chan reset");
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0, "unmapped");
    $display("test reset done");
    for (int p = 0; p < 8; p++) begin
      cmd(32'h2000 | p);
      rd(slcp_pkg::OFF_DATA, {24'h0, ptab[p]}, "param");
    end
    v = $random(seed) & 32'hff;
    wr(slcp_pkg::OFF_DATA, v);
    cmd(32'ha009);
    wr(slcp_pkg::OFF_DATA, 32'h0);
    cmd(32'h2009);
    rd(slcp_pkg::OFF_DATA, v, "param ram");
    $display("test params done");
    wr(slcp_pkg::OFF_CMD, 32'h4000);
    wr(slcp_pkg::OFF_CMD, 32'h80000800);
    rd(slcp_pkg::OFF_CMD, 32'h4000, "busy cmd");
    idle();
    cmd(32'h800009ff);
    rd(slcp_pkg::OFF_CHAN, 32'h0, "ignored start");
    $display("test busy done");
    m = $random(seed) | 1;
    cmd(32'h0900 | m);
    rd(slcp_pkg::OFF_DATA, m & ~pres, "start fails");
    m2 = $random(seed) & ~m;
    cmd(32'h0f00 | m2);
    ea = (m | m2) & pres;
    rd(slcp_pkg::OFF_CHAN, {m2 & pres, ea}, "chan");
    $display("test start done");
    for (int i = 0; i < 3; i++) begin
      dly <= (i == 1) ? 8'd40 : 8'd1;
      mute <= (i == 2) ? ea : 8'h00;
      fset <= $random(seed);
      v = $random(seed) & 32'hff;
      @(posedge clk);
      ok = ea & ~fset & ~mute;
      cmd(32'h1000 | v);
      rd(slcp_pkg::OFF_DATA, v & ~ok, "xfer fails");
    end
    $display("test transfer done");
    for (int t = 2; t < 7; t++) begin
      cmd(32'h08ff | (t << 8));
      rd(slcp_pkg::OFF_CHAN, {m2 & pres, ea}, "noop");
    end
    m = $random(seed) | 1;
    cmd(32'h0800 | m);
    rd(slcp_pkg::OFF_CHAN, {m2 & pres & ~m, ea & ~m}, "stop");
    $display("test stop done");
    wr(slcp_pkg::OFF_DATA, 32'h5a);
    cmd(32'ha00a);
    cmd(32'h0900 | pres);
    mute <= 8'hff;
    wr(slcp_pkg::OFF_CMD, 32'h10ff);
    wr(slcp_pkg::OFF_CMD, 32'h0800);
    idle();
    rd(slcp_pkg::OFF_CHAN, 32'h0, "stop all chan");
    cmd(32'h200a);
    rd(slcp_pkg::OFF_DATA, 32'h0, "ram cleared");
    check("link resets", lnk_cnt, 1);
    $display("test stop all done");
    end_sim();
  end
endmodule

// file: bench/slcp_chan_model.sv
// behavioural model of the remote channels answering transfer requests
module slcp_chan_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_req,
  input wire logic [7:0] i_fail_set,
  input wire logic [7:0] i_mute,
  input wire logic [7:0] i_dly,
  output logic [7:0] o_done,
  output logic [7:0] o_fail
);
  logic [7:0] pend_q;
  logic [7:0] cnt_q;

  // muted channels never answer, so the port must time them out
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_q <= 8'h00;
      cnt_q <= 8'h00;
      o_done <= 8'h00;
      o_fail <= 8'h00;
    end else begin
      o_done <= 8'h00;
      o_fail <= 8'h00;
      if (|i_req) begin
        pend_q <= i_req & ~i_mute;
        cnt_q <= 8'h00;
      end else if (|pend_q) begin
        if (cnt_q == i_dly) begin
          o_done <= pend_q & ~i_fail_set;
          o_fail <= pend_q & i_fail_set;
          pend_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule

// file: bench/slcp_chk_chk.sv
// assertion checker for the serial link command port
module slcp_chk (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic [7:0] I_CHAN_PRESENT,
  input wire logic [7:0] O_CHAN_ACTIVE,
  input wire logic [7:0] O_CHAN_SETUP,
  input wire logic [7:0] O_XFER_REQ,
  input wire logic O_PROC_RESET,
  input wire logic O_LINK_RESET,
  input wire logic O_PHY_CLK
);
  // the pulse covers the whole reset count, exec cycle included
  localparam int PRST_LEN = slcp_pkg::PROC_RESET_CYC;
  logic [4:0] prst_cnt_q;
  logic rd_take;
  logic wr_take;

  assign rd_take = I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE;
  assign wr_take = I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;

  // counts high cycles of the processor reset pulse
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prst_cnt_q <= 5'h00;
    end else if (O_PROC_RESET) begin
      prst_cnt_q <= prst_cnt_q + 5'h01;
    end else begin
      prst_cnt_q <= 5'h00;
    end
  end

  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  // ********
  // assertions
  // ********
  a_resp_okay: assert property (O_HRESP == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (
    rd_take |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("read data phase not exactly one wait");
  a_write_nowait: assert property (wr_take |=> O_HREADYOUT)
    else $error("write data phase stalled");
  a_proc_rst_len: assert property (
    $fell(O_PROC_RESET) |-> prst_cnt_q == PRST_LEN)
    else $error("processor reset pulse has wrong length");
  a_link_rst_pulse: assert property (
    O_LINK_RESET |=> !O_LINK_RESET)
    else $error("link reset longer than one cycle");
  a_stop_all_clr: assert property (
    O_LINK_RESET |-> ##[0:1] O_CHAN_ACTIVE == 8'h00)
    else $error("channels still active after stop all");
  a_xfer_pulse: assert property (|O_XFER_REQ |=> O_XFER_REQ == 8'h00)
    else $error("transfer request longer than one cycle");
  a_xfer_active: assert property (
    (O_XFER_REQ & ~O_CHAN_ACTIVE) == 8'h00)
    else $error("transfer requested on inactive channel");
  a_setup_active: assert property (
    (O_CHAN_SETUP & ~O_CHAN_ACTIVE) == 8'h00)
    else $error("setup flag on inactive channel");
  a_start_present: assert property (
    (O_CHAN_ACTIVE & ~$past(O_CHAN_ACTIVE) & ~$past(I_CHAN_PRESENT))
      == 8'h00)
    else $error("absent channel became active");
  a_phy_toggle: assert property (
    1'b1 |=> O_PHY_CLK != $past(O_PHY_CLK))
    else $error("network clock did not toggle");

  c_proc_rst: cover property ($rose(O_PROC_RESET));
  c_link_rst: cover property (O_LINK_RESET);
  c_xfer: cover property (|O_XFER_REQ);
endmodule

bind slcp_command_port slcp_chk u_chk (
  .I_CLK_SYS, .I_RESETN, .I_HSEL, .I_HTRANS, .I_HWRITE, .I_HREADY,
  .O_HREADYOUT, .O_HRESP, .I_CHAN_PRESENT, .O_CHAN_ACTIVE, .O_CHAN_SETUP,
  .O_XFER_REQ, .O_PROC_RESET, .O_LINK_RESET, .O_PHY_CLK
);

// file: hw/slcp_clkdiv.sv
// divide-by-two clock generator for the network interface chip
module slcp_clkdiv (
  input wire logic i_clk,
  input wire logic i_resetn,
  output logic o_clk_half
);

  logic half_q;

  // free-running toggle, so the output is exactly half the input rate
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q; // RL16
    end
  end

  assign o_clk_half = half_q;

endmodule

// file: hw/slcp_command_port.sv
// command port of the serial link engine, with its AHB-Lite register slave
//
// ****************************************************************
// Functional notes
// RL1: command word is 16 bits, right-justified
// RL2: command and data registers face the processor
// RL3: bit 15 marks a parameter write
// RL4: bit 14 resets the internal processor
// RL5: bit 13 requests parameter read or write
// RL6: bit 12 requests a data transfer cycle
// RL7: start/stop type 000 stops masked channels
// RL8: type 001 starts masked channels, normal mode
// RL9: type 111 starts masked channels, setup mode
// RL10: only masked channels are started, stopped, transferred
// RL11: a written command starts at once
// RL12: completion clears the command register to zero
// RL13: busy command register reads the written command
// RL14: host writes no command while register nonzero
// RL15: stop-all is taken anytime and resets link
// RL16: one system clock; half-rate clock for network chip
// RL17: stop-all also clears all channel variables
// RL18: writes with bit 31 set are ignored; code ignores only command writes, data writes still land
// RL19: data register returns failed-channel mask
// RL20: other start/stop types complete as no-ops
// ****************************************************************
module slcp_command_port (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  input wire logic [7:0] I_CHAN_PRESENT,
  input wire logic [7:0] I_XFER_DONE,
  input wire logic [7:0] I_XFER_FAIL,
  output logic [7:0] O_CHAN_ACTIVE,
  output logic [7:0] O_CHAN_SETUP,
  output logic [7:0] O_XFER_REQ,
  output logic O_PROC_RESET,
  output logic O_LINK_RESET,
  output logic O_PHY_CLK
);

  // revision and processor type codes: values are arbitrary
  localparam logic [7:0] MAJOR_REV = 8'h01;
  localparam logic [7:0] MINOR_REV = 8'h00;
  localparam logic [7:0] PROC_TYPE = 8'h5a;
  localparam logic [11:0] XFER_TMO =
    12'(slcp_pkg::XFER_TIMEOUT_CYC);
  localparam logic [11:0] ROMRST_LEN =
    12'(slcp_pkg::PROC_RESET_CYC);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  function automatic logic [7:0] cmd_mask(input logic [15:0] c);
    cmd_mask = c[slcp_pkg::MASK_LSB +: slcp_pkg::CHANS];
  endfunction

  function automatic logic [7:0] par_const(input logic [7:0] a);
    case (a)
      slcp_pkg::PAR_ADDR_IFTYPE: par_const = slcp_pkg::PAR_IFTYPE;
      slcp_pkg::PAR_ADDR_IFWIDTH: par_const = slcp_pkg::PAR_IFWIDTH;
      slcp_pkg::PAR_ADDR_MAJOR: par_const = MAJOR_REV;
      slcp_pkg::PAR_ADDR_MINOR: par_const = MINOR_REV;
      slcp_pkg::PAR_ADDR_GPIN: par_const = slcp_pkg::PAR_GP_NONE;
      slcp_pkg::PAR_ADDR_GPOUT: par_const = slcp_pkg::PAR_GP_NONE;
      slcp_pkg::PAR_ADDR_PROC: par_const = PROC_TYPE;
      slcp_pkg::PAR_ADDR_CHANS: par_const = slcp_pkg::PAR_CHANS;
      default: par_const = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic ap_take;
  logic dp_wr_q;
  logic dp_rd_q;
  logic [7:0] dp_addr_q;
  logic dp_hit_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic wr_en;
  logic wr_cmd;
  logic wr_data;

  logic [15:0] cmd_q;
  logic [7:0] data_q;
  logic [7:0] active_q;
  logic [7:0] setup_q;

  assign ap_take = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign wr_en = dp_wr_q & dp_hit_q;
  assign wr_cmd = wr_en & addr_is(dp_addr_q, slcp_pkg::OFF_CMD);
  assign wr_data = wr_en & addr_is(dp_addr_q, slcp_pkg::OFF_DATA);

  // reads take one wait state so that hrdata comes from a flop and
  // always reflects a write that finished in the previous cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 8'h00;
      dp_hit_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else if (dp_rd_q && !hready_q) begin
      hready_q <= 1'b1;
      dp_rd_q <= 1'b0;
      dp_wr_q <= 1'b0;
      if (!dp_hit_q) begin
        hrdata_q <= 32'h0000_0000;
      end else if (addr_is(dp_addr_q, slcp_pkg::OFF_CMD)) begin
        hrdata_q <= {16'h0000, cmd_q}; // RL1 RL13
      end else if (addr_is(dp_addr_q, slcp_pkg::OFF_DATA)) begin
        hrdata_q <= {24'h00_0000, data_q}; // RL2
      end else if (addr_is(dp_addr_q, slcp_pkg::OFF_CHAN)) begin
        hrdata_q <= {16'h0000, setup_q, active_q};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end else if (ap_take) begin
      dp_wr_q <= I_HWRITE;
      dp_rd_q <= ~I_HWRITE;
      hready_q <= I_HWRITE;
      dp_addr_q <= I_HADDR[7:0];
      dp_hit_q <= (I_HADDR[31:8] == 24'h00_0000) &
                  (I_HADDR[1:0] == 2'h0);
    end else begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  slcp_pkg::slcp_state_t state_q;
  logic [11:0] tmr_q;
  logic [7:0] pend_q;
  logic [7:0] fail_q;
  logic [7:0] xfer_req_q;
  logic proc_rst_q;
  logic link_rst_q;

  logic host_ign;
  logic host_stop_all;
  logic host_take;
  logic [15:0] host_cmd;

  logic exec;
  logic [2:0] c_type;
  logic [7:0] c_mask;
  logic do_rom;
  logic do_par;
  logic do_ss;
  logic do_xfer;
  logic do_stop;
  logic do_stop_all;
  logic do_start_n;
  logic do_start_s;
  logic [7:0] start_ok;
  logic [7:0] pend_d;
  logic [7:0] fail_d;
  logic xfer_end;

  assign host_cmd = I_HWDATA[15:0];
  assign host_ign = I_HWDATA[slcp_pkg::BIT_IGNORE]; // RL18
  assign host_stop_all = (host_cmd == slcp_pkg::CMD_STOP_ALL); // RL15
  // a write to a busy register is refused unless it is stop-all
  assign host_take = wr_cmd & ~host_ign &
                     ((state_q == slcp_pkg::ST_IDLE) | host_stop_all);

  assign exec = (state_q == slcp_pkg::ST_EXEC);
  assign c_type = cmd_q[slcp_pkg::TYPE_LSB +: 3];
  assign c_mask = cmd_mask(cmd_q);
  assign do_rom = exec & cmd_q[slcp_pkg::BIT_ROM]; // RL4
  assign do_par = exec & ~cmd_q[slcp_pkg::BIT_ROM] &
                  cmd_q[slcp_pkg::BIT_REQ]; // RL5
  assign do_ss = exec & ~cmd_q[slcp_pkg::BIT_ROM] &
                 ~cmd_q[slcp_pkg::BIT_REQ] &
                 cmd_q[slcp_pkg::BIT_STARTSTOP];
  assign do_xfer = exec & ~cmd_q[slcp_pkg::BIT_ROM] &
                   ~cmd_q[slcp_pkg::BIT_REQ] &
                   ~cmd_q[slcp_pkg::BIT_STARTSTOP] &
                   cmd_q[slcp_pkg::BIT_XFER]; // RL6
  assign do_stop = do_ss & (c_type == slcp_pkg::TYPE_STOP); // RL7
  assign do_stop_all = do_stop & (c_mask == 8'h00); // RL17
  assign do_start_n = do_ss & (c_type == slcp_pkg::TYPE_NORMAL); // RL8
  assign do_start_s = do_ss & (c_type == slcp_pkg::TYPE_SETUP); // RL9
  assign start_ok = c_mask & I_CHAN_PRESENT; // RL10

  // transfer bookkeeping: a channel leaves the pending set on done
  // or fail; fail marks it in the result mask
  assign pend_d = pend_q & ~(I_XFER_DONE | I_XFER_FAIL);
  assign fail_d = fail_q | (pend_q & I_XFER_FAIL);
  assign xfer_end = (state_q == slcp_pkg::ST_XFER) &
                    ((pend_d == 8'h00) | (tmr_q == 12'h000));

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= slcp_pkg::ST_IDLE;
      cmd_q <= slcp_pkg::CMD_RST;
      tmr_q <= 12'h000;
      pend_q <= 8'h00;
      fail_q <= 8'h00;
    end else if (host_take) begin
      // stop-all overrides any pending command, even a completing one
      cmd_q <= host_cmd; // RL1 RL11 RL15
      state_q <= slcp_pkg::ST_EXEC; // RL11
      tmr_q <= 12'h000;
      pend_q <= 8'h00;
      fail_q <= 8'h00;
    end else begin
      case (state_q)
        slcp_pkg::ST_IDLE: begin
          state_q <= slcp_pkg::ST_IDLE;
        end
        slcp_pkg::ST_EXEC: begin
          if (do_rom) begin
            tmr_q <= ROMRST_LEN - 12'h001;
            state_q <= slcp_pkg::ST_ROMRST;
          end else if (do_xfer) begin
            // inactive channels are never asked; they report failed
            pend_q <= c_mask & active_q;
            fail_q <= c_mask & ~active_q; // RL19
            tmr_q <= XFER_TMO;
            state_q <= slcp_pkg::ST_XFER;
          end else begin
            state_q <= slcp_pkg::ST_DONE; // RL20
          end
        end
        slcp_pkg::ST_XFER: begin
          pend_q <= pend_d;
          fail_q <= fail_d;
          tmr_q <= tmr_q - 12'h001;
          if (xfer_end) begin
            state_q <= slcp_pkg::ST_DONE;
          end
        end
        slcp_pkg::ST_ROMRST: begin
          tmr_q <= tmr_q - 12'h001;
          if (tmr_q == 12'h000) begin
            state_q <= slcp_pkg::ST_DONE;
          end
        end
        slcp_pkg::ST_DONE: begin
          cmd_q <= slcp_pkg::CMD_RST; // RL12
          state_q <= slcp_pkg::ST_IDLE;
        end
        default: begin
          cmd_q <= slcp_pkg::CMD_RST;
          state_q <= slcp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // channel state
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      active_q <= slcp_pkg::CHAN_RST;
      setup_q <= slcp_pkg::CHAN_RST;
    end else if (do_stop_all) begin
      active_q <= slcp_pkg::CHAN_RST; // RL17
      setup_q <= slcp_pkg::CHAN_RST;
    end else if (do_stop) begin
      active_q <= active_q & ~c_mask; // RL7 RL10
      setup_q <= setup_q & ~c_mask;
    end else if (do_start_n) begin
      active_q <= active_q | start_ok; // RL8
      setup_q <= setup_q & ~start_ok;
    end else if (do_start_s) begin
      active_q <= active_q | start_ok; // RL9
      setup_q <= setup_q | start_ok;
    end
  end

  // transfer request: one-cycle pulse on each channel asked to move
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      xfer_req_q <= 8'h00;
    end else if (do_xfer) begin
      xfer_req_q <= c_mask & active_q; // RL6 RL10
    end else begin
      xfer_req_q <= 8'h00;
    end
  end

  // ****************************************************************
  // local parameter storage
  // ****************************************************************
  logic [7:0] par_ram [slcp_pkg::PAR_RAM_DEPTH];
  logic par_in_ram;
  logic [2:0] par_idx;
  logic [7:0] par_rd;

  assign par_in_ram = (c_mask[7:3] == slcp_pkg::PAR_RAM_BASE[7:3]);
  assign par_idx = c_mask[2:0];
  assign par_rd = par_in_ram ? par_ram[par_idx] : par_const(c_mask);

  // the fixed parameters are read only; writes to them are dropped
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < slcp_pkg::PAR_RAM_DEPTH; i++) begin
        par_ram[i] <= 8'h00;
      end
    end else if (do_stop_all) begin
      for (int i = 0; i < slcp_pkg::PAR_RAM_DEPTH; i++) begin
        par_ram[i] <= 8'h00; // RL17
      end
    end else if (do_par && cmd_q[slcp_pkg::BIT_WRITE] && par_in_ram) begin
      par_ram[par_idx] <= data_q; // RL3
    end
  end

  // ****************************************************************
  // data register
  // ****************************************************************
  // hardware results win over a host write landing in the same cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      data_q <= slcp_pkg::DATA_RST;
    end else if (do_start_n || do_start_s) begin
      data_q <= c_mask & ~I_CHAN_PRESENT; // RL19
    end else if (xfer_end) begin
      data_q <= fail_d | pend_d; // RL19
    end else if (do_par && !cmd_q[slcp_pkg::BIT_WRITE]) begin
      data_q <= par_rd; // RL5
    end else if (wr_data) begin
      data_q <= I_HWDATA[7:0]; // RL2
    end
  end

  // ****************************************************************
  // resets toward the processor and the link
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      proc_rst_q <= 1'b0;
      link_rst_q <= 1'b0;
    end else begin
      proc_rst_q <= do_rom | (state_q == slcp_pkg::ST_ROMRST &&
                              tmr_q != 12'h000); // RL4
      link_rst_q <= do_stop_all; // RL15
    end
  end

  // ****************************************************************
  // network chip clock
  // ****************************************************************
  slcp_clkdiv u_clkdiv (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .o_clk_half(O_PHY_CLK)
  );

  // hsize is not checked: only whole-word transfers are supported
  assign O_HREADYOUT = hready_q;
  assign O_HRDATA = hrdata_q;
  assign O_HRESP = 1'b0;
  assign O_CHAN_ACTIVE = active_q;
  assign O_CHAN_SETUP = setup_q;
  assign O_XFER_REQ = xfer_req_q;
  assign O_PROC_RESET = proc_rst_q;
  assign O_LINK_RESET = link_rst_q;

endmodule

// file: hw/slcp_pkg.sv
// constants, register map and state type of the serial link command port
package slcp_pkg;

  // ****************************************************************
  // register map (byte addresses on the AHB-Lite bus)
  // ****************************************************************
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_CHAN = 8'h08;
  localparam int unsigned ADDR_DEC_W = 8;

  // ****************************************************************
  // command word layout
  // ****************************************************************
  localparam int unsigned CMD_W = 16;
  localparam int unsigned BIT_IGNORE = 31;
  localparam int unsigned BIT_WRITE = 15;
  localparam int unsigned BIT_ROM = 14;
  localparam int unsigned BIT_REQ = 13;
  localparam int unsigned BIT_XFER = 12;
  localparam int unsigned BIT_STARTSTOP = 11;
  localparam int unsigned TYPE_LSB = 8;
  localparam int unsigned MASK_LSB = 0;
  localparam int unsigned CHANS = 8;
  localparam logic [2:0] TYPE_STOP = 3'h0;
  localparam logic [2:0] TYPE_NORMAL = 3'h1;
  localparam logic [2:0] TYPE_SETUP = 3'h7;
  localparam logic [15:0] CMD_STOP_ALL = 16'h0800;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;

  // ****************************************************************
  // local parameter space
  // ****************************************************************
  localparam logic [7:0] PAR_ADDR_IFTYPE = 8'h00;
  localparam logic [7:0] PAR_ADDR_IFWIDTH = 8'h01;
  localparam logic [7:0] PAR_ADDR_MAJOR = 8'h02;
  localparam logic [7:0] PAR_ADDR_MINOR = 8'h03;
  localparam logic [7:0] PAR_ADDR_GPIN = 8'h04;
  localparam logic [7:0] PAR_ADDR_GPOUT = 8'h05;
  localparam logic [7:0] PAR_ADDR_PROC = 8'h06;
  localparam logic [7:0] PAR_ADDR_CHANS = 8'h07;
  localparam logic [7:0] PAR_RAM_BASE = 8'h08;
  localparam int unsigned PAR_RAM_DEPTH = 8;
  localparam logic [7:0] PAR_IFTYPE = 8'h12;
  localparam logic [7:0] PAR_IFWIDTH = 8'h08;
  localparam logic [7:0] PAR_GP_NONE = 8'h00;
  localparam logic [7:0] PAR_CHANS = 8'h08;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned XFER_TIMEOUT_US = 100;
  localparam int unsigned XFER_TIMEOUT_CYC = XFER_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned PROC_RESET_NS = 500;
  localparam int unsigned PROC_RESET_CYC =
    (PROC_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W = 12;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_XFER,
    ST_ROMRST,
    ST_DONE
  } slcp_state_t;

endpackage
